// File: pkg/mfd_defines.svh
`ifndef MFD_DEFINES_SVH
`define MFD_DEFINES_SVH

// microword geometry; rcm bit n sits at word index n-1
`define MFD_WORD_W 80
`define MFD_FIELD_CNT 13
`define MFD_PAR_CNT 8
`define MFD_PAR_GRP 10
`define MFD_PAR_DATA 9
`define MFD_UADDR_W 17
`define MFD_EA_LOW_W 16
`define MFD_ALU_W 56
`define MFD_SHIFT_MAX 6'h30

// field positions (word index, low part first)
`define MFD_CU_A_MSB 1
`define MFD_CU_A_LSB 0
`define MFD_TR_BIT 2
`define MFD_EAE_MSB 5
`define MFD_EAE_LSB 3
`define MFD_BDL_A_MSB 8
`define MFD_BDL_A_LSB 6
`define MFD_BDL_B_MSB 12
`define MFD_BDL_B_LSB 10
`define MFD_ALU_A_MSB 18
`define MFD_ALU_A_LSB 13
`define MFD_ALU_B_MSB 21
`define MFD_ALU_B_LSB 20
`define MFD_DST_A_MSB 28
`define MFD_DST_A_LSB 22
`define MFD_DST_B_BIT 30
`define MFD_CU_B_MSB 35
`define MFD_CU_B_LSB 31
`define MFD_CS_MSB 38
`define MFD_CS_LSB 36
`define MFD_B_OPERAND_SELECT_MSB 44
`define MFD_B_OPERAND_SELECT_LSB 40
`define MFD_RFS_A_MSB 48
`define MFD_RFS_A_LSB 45
`define MFD_RFS_B_MSB 52
`define MFD_RFS_B_LSB 50
`define MFD_RFD_MSB 54
`define MFD_RFD_LSB 53
`define MFD_IAC_A_MSB 58
`define MFD_IAC_A_LSB 55
`define MFD_IAC_B_MSB 63
`define MFD_IAC_B_LSB 60
`define MFD_STEP_EXTEND_COUNT_MSB 67
`define MFD_STEP_EXTEND_COUNT_LSB 64
`define MFD_CU_C_BIT 68
`define MFD_CU_D_MSB 78
`define MFD_CU_D_LSB 70
`define MFD_SUB_HI_BIT 31
`define MFD_SUB_LO_BIT 32

// sequencer-op codes and the 010 subselect
`define MFD_SEQ_RTN 3'h0
`define MFD_SEQ_JUMP 3'h1
`define MFD_SEQ_SPECIAL 3'h2
`define MFD_SEQ_EMIT 3'h3
`define MFD_SEQ_CONDITIONAL_RETURN 3'h4
`define MFD_SEQ_CALLJ 3'h5
`define MFD_SEQ_CALLG 3'h6
`define MFD_SEQ_PUSHE 3'h7
`define MFD_SUB_DECODE 2'h0
`define MFD_SUB_BDH 2'h1
`define MFD_SUB_LDA 2'h2
`define MFD_SUB_GOTO 2'h3

// effective-address step codes
`define MFD_EAE_NONE 3'h0
`define MFD_EAE_SINC 3'h1
`define MFD_EAE_SDEC 3'h2
`define MFD_EAE_DINC 3'h3
`define MFD_EAE_DDEC 3'h4
`define MFD_EAE_BINC 3'h5
`define MFD_EAE_BDEC 3'h6
`define MFD_EAE_XCHG 3'h7

// a-leg sources (code in top 3 bits of the alu field)
`define MFD_ASRC_RF 3'h0
`define MFD_ASRC_MUL 3'h1
`define MFD_ASRC_CONST 3'h2
`define MFD_ASRC_BUS 3'h3
`define MFD_ASRC_PCL 3'h4
`define MFD_ASRC_NORM 3'h5
`define MFD_ASRC_CNT 6

// step timing
`define MFD_CLK_PERIOD_PS 20000
`define MFD_EXT_UNIT_PS 31250
`define MFD_EXT_UNIT_CYC \
  ((`MFD_EXT_UNIT_PS + `MFD_CLK_PERIOD_PS - 1) / `MFD_CLK_PERIOD_PS)
`define MFD_PRE_P7_CYC 4
`define MFD_P7_P8_CYC 2
`define MFD_P8_LATCH_CYC 2
`define MFD_STACK_DEPTH 4

`endif

// File: pkg/mfd_pkg.sv
package mfd_pkg;
  typedef logic [16:0] mfd_uaddr_t;
  typedef logic [79:0] mfd_word_t;
  typedef enum logic [1:0] {
    MFD_ST_IDLE,
    MFD_ST_PRE,
    MFD_ST_P78,
    MFD_ST_P8L
  } mfd_step_state_t;
endpackage

// File: rtl/mfd_step_timer.sv
`timescale 1ns/10ps
`include "mfd_defines.svh"
module mfd_step_timer #(
  parameter int unsigned PRE_CYC = `MFD_PRE_P7_CYC,
  parameter int unsigned P78_CYC = `MFD_P7_P8_CYC,
  parameter int unsigned P8L_CYC = `MFD_P8_LATCH_CYC,
  parameter int unsigned EXT_CYC = `MFD_EXT_UNIT_CYC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // step control
  input wire logic start_in,
  input wire logic [1:0] tx_count_in,
  input wire logic [1:0] nx_count_in,
  // beat phase pulses
  output logic phase7_out,
  output logic phase8_out,
  output logic latch_out
);
  import mfd_pkg::*;

  mfd_step_state_t state_ff;
  logic [7:0] cnt_ff;
  logic cnt_zero;
  logic [7:0] nxt_p78;
  logic [7:0] nxt_p8l;

  assign cnt_zero = (cnt_ff == 8'h00);
  // extension counts add whole units of the rounded-up ext period
  assign nxt_p78 = 8'(P78_CYC + 32'(tx_count_in) * EXT_CYC - 1);
  assign nxt_p8l = 8'(P8L_CYC + 32'(nx_count_in) * EXT_CYC - 1);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_ff <= MFD_ST_IDLE;
    end else begin
      case (state_ff)
        MFD_ST_IDLE: if (start_in) state_ff <= MFD_ST_PRE;
        MFD_ST_PRE: if (cnt_zero) state_ff <= MFD_ST_P78;
        MFD_ST_P78: if (cnt_zero) state_ff <= MFD_ST_P8L;
        MFD_ST_P8L: if (cnt_zero) state_ff <= MFD_ST_IDLE;
        default: state_ff <= MFD_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cnt_ff <= 8'h00;
    end else begin
      case (state_ff)
        MFD_ST_IDLE: cnt_ff <= 8'(PRE_CYC - 1);
        MFD_ST_PRE: cnt_ff <= cnt_zero ? nxt_p78 : cnt_ff - 8'h01;
        MFD_ST_P78: cnt_ff <= cnt_zero ? nxt_p8l : cnt_ff - 8'h01;
        MFD_ST_P8L: cnt_ff <= cnt_zero ? 8'h00 : cnt_ff - 8'h01;
        default: cnt_ff <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      phase7_out <= 1'b0;
      phase8_out <= 1'b0;
      latch_out <= 1'b0;
    end else begin
      phase7_out <= (state_ff == MFD_ST_PRE) && cnt_zero;
      phase8_out <= (state_ff == MFD_ST_P78) && cnt_zero;
      latch_out <= (state_ff == MFD_ST_P8L) && cnt_zero;
    end
  end
endmodule

// File: rtl/mfd_decoder.sv
// Behaviour
// - Accept an 80-bit microword of 13 fields, each decoded independently.
// - A 3-bit field steps only the low 16 bits of both EA registers.
// - An 8-bit field drives the 56-bit ALU and selects the A-leg source.
// - A 5-bit field picks 16 upper and 2 lower B-leg sources.
// - A 6-bit field controls the barrel shifter operation.
// - An 8-bit side-action code fires infrequent peripheral functions.
// - A 7-bit source and a 2-bit destination select register-file entries.
// - Next microaddress comes from 3-bit sequencer op and 17-bit field.
// - Sequencer op decides if the 17-bit field is constant or address.
// - Ops: return, jump, emit, conditional return, calls, push with emit.
// - Op 010 subselects decode, bus-data-high branch, load address, goto.
// - An 8-bit destination field writes its targets at step end.
// - A 4-bit extension field sets the microstep length.
// - Each early count adds 31.25 ns rounded up to 2 cycles (40 ns) between phases seven and eight.
// - Each late count adds 31.25 ns rounded up to 2 cycles (40 ns) between phase eight and step latch.
// - Trap inhibit set blocks direct-transfer channel traps this step.
// - Eight parity bits at positions 10..80 are generated and checked.
// - A shift amount up to 48 goes to the barrel shifter in one step.
// - Multiplier digits use 3-bit Booth recoding for a 3-operand adder.
// - Division uses non-restoring add or subtract per step.
`timescale 1ns/10ps
`include "mfd_defines.svh"
module mfd_decoder #(
  parameter bit ODD_PARITY = 1'b1,
  parameter int unsigned STACK_DEPTH = `MFD_STACK_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // control store
  input wire mfd_pkg::mfd_word_t word_in,
  input wire logic word_valid_in,
  output logic word_ready_out,
  input wire mfd_pkg::mfd_word_t cs_wr_word_in,
  output mfd_pkg::mfd_word_t cs_wr_word_out,
  output logic parity_err_out,
  // sequencer inputs
  input wire logic branch_cond_in,
  input wire mfd_pkg::mfd_uaddr_t decode_addr_in,
  input wire mfd_pkg::mfd_uaddr_t load_addr_in,
  input wire logic [3:0] bus_data_high_in,
  // sequencer outputs
  output mfd_pkg::mfd_uaddr_t next_addr_out,
  output logic next_addr_valid_out,
  output logic [16:0] constant_out,
  output logic constant_valid_out,
  // beat phases
  output logic beat_phase_seven_out,
  output logic beat_phase_eight_out,
  output logic step_latch_phase_out,
  // datapath inputs
  input wire logic trap_req_in,
  input wire logic [15:0] ea_source_reg_low_in,
  input wire logic [15:0] ea_dest_reg_low_in,
  input wire logic [5:0] shift_count_in,
  input wire logic [3:0] mult_bits_in,
  input wire logic div_rem_neg_in,
  // datapath control
  output logic [5:0] a_src_sel_out,
  output logic [4:0] alu_func_out,
  output logic [3:0] b_hi_src_out,
  output logic b_lo_src_out,
  output logic [5:0] shifter_ctrl_out,
  output logic [5:0] shift_amount_out,
  output logic [7:0] side_action_code_out,
  output logic side_action_strobe_out,
  output logic [6:0] regfile_source_select_out,
  output logic [1:0] regfile_dest_select_out,
  output logic [7:0] dest_write_en_out,
  output logic trap_take_out,
  output logic [15:0] ea_source_reg_low_out,
  output logic [15:0] ea_dest_reg_low_out,
  output logic ea_update_out,
  output logic [3:0] booth_digit_out,
  output logic div_add_out
);
  import mfd_pkg::*;

  localparam int unsigned SP_W = $clog2(STACK_DEPTH);

  // field views of the incoming word
  logic [16:0] in_cu;
  logic [2:0] in_seq_op;
  logic [1:0] in_sub;
  logic [7:0] in_alu;
  logic [7:0] in_dst;
  logic [5:0] in_bdl;
  logic [6:0] in_rfs;
  logic [7:0] in_iac;
  logic [7:0] par_bad;
  logic accept;

  // stored microword fields
  logic [16:0] next_addr_or_constant_ff;
  logic [2:0] seq_op_ff;
  logic [1:0] sub_op_ff;
  logic [2:0] ea_step_ctrl_ff;
  logic [3:0] step_extend_count_ff;
  logic [7:0] dest_write_select_ff;
  logic [7:0] side_action_ff;
  logic trap_inhibit_ff;
  logic step_par_bad_ff;
  logic start_ff;

  // sequencer state
  logic [16:0] stack_ff [STACK_DEPTH];
  logic [SP_W-1:0] sp_ff;
  logic [16:0] nxt_addr;
  logic [16:0] push_val;
  logic [16:0] stack_top;
  logic push;
  logic pop;
  logic emit;
  logic t_phase7;
  logic t_phase8;
  logic t_latch;

  // rcm bit n is word index n-1; the lower rcm bit is the field lsb, except in the subselect where it is the msb
  assign in_cu = {word_in[`MFD_CU_D_MSB:`MFD_CU_D_LSB],
                  word_in[`MFD_CU_C_BIT],
                  word_in[`MFD_CU_B_MSB:`MFD_CU_B_LSB],
                  word_in[`MFD_CU_A_MSB:`MFD_CU_A_LSB]};
  // sequencer op is taken only from rcm 37-39
  assign in_seq_op = word_in[`MFD_CS_MSB:`MFD_CS_LSB];
  assign in_sub = {word_in[`MFD_SUB_HI_BIT], word_in[`MFD_SUB_LO_BIT]};
  assign in_alu = {word_in[`MFD_ALU_B_MSB:`MFD_ALU_B_LSB],
                   word_in[`MFD_ALU_A_MSB:`MFD_ALU_A_LSB]};
  assign in_dst = {word_in[`MFD_DST_B_BIT],
                   word_in[`MFD_DST_A_MSB:`MFD_DST_A_LSB]};
  assign in_bdl = {word_in[`MFD_BDL_B_MSB:`MFD_BDL_B_LSB],
                   word_in[`MFD_BDL_A_MSB:`MFD_BDL_A_LSB]};
  assign in_rfs = {word_in[`MFD_RFS_B_MSB:`MFD_RFS_B_LSB],
                   word_in[`MFD_RFS_A_MSB:`MFD_RFS_A_LSB]};
  assign in_iac = {word_in[`MFD_IAC_B_MSB:`MFD_IAC_B_LSB],
                   word_in[`MFD_IAC_A_MSB:`MFD_IAC_A_LSB]};
  assign accept = word_valid_in && word_ready_out;

  // each group of nine bits is covered by the tenth
  for (genvar g = 0; g < `MFD_PAR_CNT; g++) begin : g_par
    assign par_bad[g] = (^word_in[g*`MFD_PAR_GRP +: `MFD_PAR_GRP])
                        ^ ODD_PARITY;
    always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
        cs_wr_word_out[g*`MFD_PAR_GRP +: `MFD_PAR_GRP] <= '0;
      end else begin
        cs_wr_word_out[g*`MFD_PAR_GRP +: `MFD_PAR_DATA] <=
          cs_wr_word_in[g*`MFD_PAR_GRP +: `MFD_PAR_DATA];
        cs_wr_word_out[g*`MFD_PAR_GRP + `MFD_PAR_DATA] <=
          (^cs_wr_word_in[g*`MFD_PAR_GRP +: `MFD_PAR_DATA])
          ^ ODD_PARITY;
      end
    end
  end

  mfd_step_timer u_timer (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .start_in(start_ff),
    .tx_count_in(step_extend_count_ff[3:2]),
    .nx_count_in(step_extend_count_ff[1:0]),
    .phase7_out(t_phase7),
    .phase8_out(t_phase8),
    .latch_out(t_latch)
  );

  assign beat_phase_seven_out = t_phase7;
  assign beat_phase_eight_out = t_phase8;
  assign step_latch_phase_out = t_latch;

  // one word in flight; the next is taken once the step latches
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      word_ready_out <= 1'b1;
      start_ff <= 1'b0;
    end else begin
      start_ff <= accept;
      if (accept) begin
        word_ready_out <= 1'b0;
      end else if (t_latch) begin
        word_ready_out <= 1'b1;
      end
    end
  end

  // fields used at the step latch
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      next_addr_or_constant_ff <= 17'h0_0000;
      seq_op_ff <= `MFD_SEQ_EMIT;
      sub_op_ff <= `MFD_SUB_DECODE;
      ea_step_ctrl_ff <= `MFD_EAE_NONE;
      step_extend_count_ff <= 4'h0;
      dest_write_select_ff <= 8'h00;
      side_action_ff <= 8'h00;
      trap_inhibit_ff <= 1'b0;
      step_par_bad_ff <= 1'b0;
    end else if (accept) begin
      next_addr_or_constant_ff <= in_cu;
      seq_op_ff <= in_seq_op;
      sub_op_ff <= in_sub;
      ea_step_ctrl_ff <= word_in[`MFD_EAE_MSB:`MFD_EAE_LSB];
      step_extend_count_ff <= word_in[`MFD_STEP_EXTEND_COUNT_MSB:`MFD_STEP_EXTEND_COUNT_LSB];
      dest_write_select_ff <= in_dst;
      side_action_ff <= in_iac;
      trap_inhibit_ff <= word_in[`MFD_TR_BIT];
      step_par_bad_ff <= |par_bad;
    end
  end

  // datapath selects stand for the whole step
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      a_src_sel_out <= 6'h01;
      alu_func_out <= 5'h00;
      b_hi_src_out <= 4'h0;
      b_lo_src_out <= 1'b0;
      shifter_ctrl_out <= 6'h00;
      shift_amount_out <= 6'h00;
      regfile_source_select_out <= 7'h00;
      regfile_dest_select_out <= 2'h0;
      side_action_code_out <= 8'h00;
      parity_err_out <= 1'b0;
    end else if (accept) begin
      // unused a-leg codes fall back to the register file
      a_src_sel_out <= (in_alu[7:5] < 3'(`MFD_ASRC_CNT)) ?
                       6'(6'h01 << in_alu[7:5]) : 6'h01;
      alu_func_out <= in_alu[4:0];
      b_hi_src_out <= word_in[`MFD_B_OPERAND_SELECT_MSB:`MFD_B_OPERAND_SELECT_LSB+1];
      b_lo_src_out <= word_in[`MFD_B_OPERAND_SELECT_LSB];
      shifter_ctrl_out <= in_bdl;
      // counts above 48 would exceed the shifter's reach
      shift_amount_out <= (shift_count_in > `MFD_SHIFT_MAX) ?
                          `MFD_SHIFT_MAX : shift_count_in;
      regfile_source_select_out <= in_rfs;
      regfile_dest_select_out <= word_in[`MFD_RFD_MSB:`MFD_RFD_LSB];
      side_action_code_out <= in_iac;
      parity_err_out <= |par_bad;
    end
  end

  // arithmetic helpers, sampled once per step at phase seven
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      booth_digit_out <= 4'h0;
      div_add_out <= 1'b0;
    end else if (t_phase7) begin
      // radix-8 digit: -4*b3 + 2*b2 + b1 + b0, two's complement
      booth_digit_out <= 4'({3'h0, mult_bits_in[0]})
                         + 4'({3'h0, mult_bits_in[1]})
                         + 4'({2'h0, mult_bits_in[2], 1'b0})
                         - 4'({1'b0, mult_bits_in[3], 2'h0});
      div_add_out <= div_rem_neg_in;
    end
  end

  // end-of-step strobes; a bad parity step raises no write, side-action or EA-update strobe
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      dest_write_en_out <= 8'h00;
      side_action_strobe_out <= 1'b0;
      trap_take_out <= 1'b0;
      ea_update_out <= 1'b0;
    end else begin
      dest_write_en_out <= (t_latch && !step_par_bad_ff) ?
                           dest_write_select_ff : 8'h00;
      side_action_strobe_out <= t_latch && !step_par_bad_ff
                                && (side_action_ff != 8'h00);
      trap_take_out <= t_latch && trap_req_in
                       && !trap_inhibit_ff;
      ea_update_out <= t_latch && !step_par_bad_ff
                       && (ea_step_ctrl_ff != `MFD_EAE_NONE);
    end
  end

  // only the low halves step; carries never reach the upper bits
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ea_source_reg_low_out <= 16'h0000;
      ea_dest_reg_low_out <= 16'h0000;
    end else if (t_latch) begin
      ea_source_reg_low_out <= ea_source_reg_low_in;
      ea_dest_reg_low_out <= ea_dest_reg_low_in;
      case (ea_step_ctrl_ff)
        `MFD_EAE_SINC: ea_source_reg_low_out <= ea_source_reg_low_in + 16'h1;
        `MFD_EAE_SDEC: ea_source_reg_low_out <= ea_source_reg_low_in - 16'h1;
        `MFD_EAE_DINC: ea_dest_reg_low_out <= ea_dest_reg_low_in + 16'h1;
        `MFD_EAE_DDEC: ea_dest_reg_low_out <= ea_dest_reg_low_in - 16'h1;
        `MFD_EAE_BINC: begin
          ea_source_reg_low_out <= ea_source_reg_low_in + 16'h1;
          ea_dest_reg_low_out <= ea_dest_reg_low_in + 16'h1;
        end
        `MFD_EAE_BDEC: begin
          ea_source_reg_low_out <= ea_source_reg_low_in - 16'h1;
          ea_dest_reg_low_out <= ea_dest_reg_low_in - 16'h1;
        end
        `MFD_EAE_XCHG: begin
          ea_source_reg_low_out <= ea_source_reg_low_in + 16'h1;
          ea_dest_reg_low_out <= ea_dest_reg_low_in - 16'h1;
        end
        default: ;
      endcase
    end
  end

  assign stack_top = stack_ff[SP_W'(sp_ff - 1'b1)];

  // next-address selection
  always_comb begin
    nxt_addr = next_addr_out + 17'h0_0001;
    push_val = next_addr_out + 17'h0_0001;
    push = 1'b0;
    pop = 1'b0;
    emit = 1'b0;
    case (seq_op_ff)
      `MFD_SEQ_RTN: begin
        nxt_addr = stack_top;
        pop = 1'b1;
      end
      `MFD_SEQ_JUMP: begin
        if (branch_cond_in) nxt_addr = next_addr_or_constant_ff;
      end
      `MFD_SEQ_SPECIAL: begin
        case (sub_op_ff)
          `MFD_SUB_DECODE: nxt_addr = decode_addr_in;
          `MFD_SUB_BDH: nxt_addr = {next_addr_or_constant_ff[16:4],
                                    next_addr_or_constant_ff[3:0]
                                    | bus_data_high_in};
          `MFD_SUB_LDA: nxt_addr = load_addr_in;
          `MFD_SUB_GOTO: nxt_addr = next_addr_or_constant_ff;
          default: nxt_addr = next_addr_or_constant_ff;
        endcase
      end
      `MFD_SEQ_EMIT: emit = 1'b1;
      `MFD_SEQ_CONDITIONAL_RETURN: begin
        if (branch_cond_in) begin
          nxt_addr = stack_top;
          pop = 1'b1;
        end
      end
      `MFD_SEQ_CALLJ: begin
        if (branch_cond_in) begin
          nxt_addr = next_addr_or_constant_ff;
          push = 1'b1;
        end
      end
      `MFD_SEQ_CALLG: begin
        nxt_addr = next_addr_or_constant_ff;
        push = 1'b1;
      end
      `MFD_SEQ_PUSHE: begin
        push_val = next_addr_or_constant_ff;
        push = 1'b1;
        emit = 1'b1;
      end
      default: nxt_addr = next_addr_out + 17'h0_0001;
    endcase
  end

  // sequencer commit at the step latch
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      next_addr_out <= 17'h0_0000;
      next_addr_valid_out <= 1'b0;
      constant_out <= 17'h0_0000;
      constant_valid_out <= 1'b0;
    end else begin
      next_addr_valid_out <= t_latch;
      constant_valid_out <= t_latch && emit;
      if (t_latch) begin
        next_addr_out <= nxt_addr;
      end
      if (t_latch && emit) begin
        constant_out <= next_addr_or_constant_ff;
      end
    end
  end

  // return stack; the pointer wraps, so deep nesting overwrites
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sp_ff <= '0;
    end else if (t_latch && push) begin
      sp_ff <= SP_W'(sp_ff + 1'b1);
    end else if (t_latch && pop) begin
      sp_ff <= SP_W'(sp_ff - 1'b1);
    end
  end

  for (genvar e = 0; e < STACK_DEPTH; e++) begin : g_stack
    always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
        stack_ff[e] <= 17'h0_0000;
      end else if (t_latch && push && (sp_ff == SP_W'(e))) begin
        stack_ff[e] <= push_val;
      end
    end
  end
endmodule

// File: tb/mfd_decoder_sva.sv
`timescale 1ns/10ps
module mfd_decoder_sva (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // watched ports
  input wire mfd_pkg::mfd_word_t word_in,
  input wire logic word_valid_in,
  input wire logic word_ready_out,
  input wire logic trap_req_in,
  input wire logic beat_phase_seven_out,
  input wire logic beat_phase_eight_out,
  input wire logic step_latch_phase_out,
  input wire logic next_addr_valid_out,
  input wire logic [7:0] dest_write_en_out,
  input wire logic trap_take_out,
  input wire logic [5:0] a_src_sel_out,
  input wire logic [5:0] shift_amount_out
);
  import mfd_pkg::*;
  logic [7:0] c78_ff;
  logic [7:0] c8l_ff;
  logic [4:0] step_ff;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // gap counters restart on the pulse that opens each interval
  always_ff @(posedge sys_clk_in) begin
    c78_ff <= beat_phase_seven_out ? 8'h01 : c78_ff + 8'h01;
  end
  always_ff @(posedge sys_clk_in) begin
    c8l_ff <= beat_phase_eight_out ? 8'h01 : c8l_ff + 8'h01;
  end
  // ext counts and trap inhibit of the word in flight
  always_ff @(posedge sys_clk_in) begin
    if (word_valid_in && word_ready_out) begin
      step_ff <= {word_in[67:64], word_in[2]};
    end
  end
  sequence s_take;
    word_valid_in && word_ready_out;
  endsequence
  sequence s_done;
    next_addr_valid_out && word_ready_out;
  endsequence
  a_ready_drop: assert property (s_take |=> !word_ready_out)
    else $error("ready stayed high after a take");
  a_phase7_start: assert property (s_take |-> ##6 beat_phase_seven_out)
    else $error("phase seven not six cycles after take");
  a_early_gap: assert property (beat_phase_eight_out |->
    c78_ff == 8'h02 + {5'h00, step_ff[4:3], 1'b0})
    else $error("phase seven to eight gap wrong");
  a_late_gap: assert property (step_latch_phase_out |->
    c8l_ff == 8'h02 + {5'h00, step_ff[2:1], 1'b0})
    else $error("phase eight to latch gap wrong");
  a_step_close: assert property (step_latch_phase_out |=> s_done)
    else $error("no next address after latch");
  a_dest_late: assert property (|dest_write_en_out |->
    $past(step_latch_phase_out))
    else $error("destination write outside step end");
  a_trap_gate: assert property (step_latch_phase_out && trap_req_in |=>
    trap_take_out == !step_ff[0])
    else $error("trap taken against inhibit");
  a_shift_clamp: assert property (shift_amount_out <= 6'h30)
    else $error("shift amount above limit");
  a_aleg_onehot: assert property ($onehot(a_src_sel_out))
    else $error("a leg select not one hot");
endmodule
bind mfd_decoder mfd_decoder_sva u_sva (.*);

// File: tb/mfd_cstore_model.sv
`timescale 1ns/10ps
module mfd_cstore_model (
  // clock
  input wire logic sys_clk_in,
  // microword to the decoder
  output mfd_pkg::mfd_word_t word_out,
  output logic valid_out
);
  import mfd_pkg::*;
  initial begin
    word_out = '0;
    valid_out = 1'b0;
  end
  function automatic mfd_word_t add_par(input mfd_word_t w);
    mfd_word_t r;
    r = w;
    for (int g = 0; g < 8; g++) begin
      r[10*g+9] = ~^w[10*g+:9];
    end
    return r;
  endfunction
  // caller saw ready high
  task automatic send(input mfd_word_t w, input logic bad);
    @(posedge sys_clk_in);
    word_out <= add_par(w) ^ {bad, 79'h0};
    valid_out <= 1'b1;
    @(posedge sys_clk_in);
    valid_out <= 1'b0;
    // a released bus shows no stale word
    word_out <= ~word_out;
  endtask
endmodule

// File: tb/tb_microword_field_decoder.sv
`timescale 1ns/10ps
module tb_microword_field_decoder;
  import mfd_pkg::*;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  mfd_word_t word_in, cs_wr_word_in, cs_wr_word_out;
  mfd_uaddr_t decode_addr_in, load_addr_in, next_addr_out;
  logic word_valid_in, word_ready_out, parity_err_out, branch_cond_in;
  logic next_addr_valid_out, constant_valid_out, trap_req_in, trap_take_out;
  logic beat_phase_seven_out, beat_phase_eight_out, step_latch_phase_out;
  logic b_lo_src_out, side_action_strobe_out, ea_update_out;
  logic [3:0] bus_data_high_in, b_hi_src_out;
  logic [16:0] constant_out;
  logic [15:0] ea_source_reg_low_in, ea_dest_reg_low_in;
  logic [15:0] ea_source_reg_low_out, ea_dest_reg_low_out;
  logic [5:0] shift_count_in, a_src_sel_out, shifter_ctrl_out;
  logic [5:0] shift_amount_out;
  logic [4:0] alu_func_out;
  logic [7:0] side_action_code_out, dest_write_en_out;
  logic [6:0] regfile_source_select_out;
  logic [1:0] regfile_dest_select_out;
  logic [3:0] mult_bits_in, booth_digit_out;
  logic div_rem_neg_in, div_add_out;
  int mismatches = 0;
  int checks = 0;
  int n7, n8, nl;
  always #10 sys_clk_in = ~sys_clk_in;
  mfd_cstore_model u_cs (.sys_clk_in, .word_out(word_in),
    .valid_out(word_valid_in));
  mfd_decoder u_dut (.*);
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask
  // one microstep; returns a cycle after the latch
  task automatic step(input mfd_word_t w, input logic bad, input logic cond,
      input logic trq);
    int n;
    @(posedge sys_clk_in);
    branch_cond_in <= cond;
    trap_req_in <= trq;
    #1;
    n = 0;
    while (word_ready_out !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    if (n >= 50) begin
      mismatches++;
      final_report();
    end
    u_cs.send(w, bad);
    #1;
    {n7, n8, nl} = '0;
    n = 0;
    while (nl == 0 && n < 60) begin
      tick();
      n++;
      if (beat_phase_seven_out === 1'b1) n7 = n;
      if (beat_phase_eight_out === 1'b1) n8 = n;
      if (step_latch_phase_out === 1'b1) nl = n;
    end
    if (nl == 0) begin
      mismatches++;
      final_report();
    end
    tick();
  endtask
  task automatic t_fields();
    mfd_word_t w;
    w = '0;
    w[63:40] = {4'hC, 1'b0, 4'h3, 2'h2, 3'h5, 1'b0, 4'hA, 5'h16};
    w[30:6] = {2'h2, 7'h25, 2'h1, 1'b0, 6'h13, 3'h5, 1'b0, 3'h5};
    step(w, 1'b0, 1'b0, 1'b0);
    chk({b_hi_src_out, b_lo_src_out}, 5'h16);
    chk(regfile_source_select_out, 7'h5A);
    chk(regfile_dest_select_out, 2'h2);
    chk({side_action_strobe_out, side_action_code_out}, 9'h1C3);
    chk(shifter_ctrl_out, 6'h2D);
    chk({a_src_sel_out, alu_func_out}, {6'h04, 5'h13});
    chk({parity_err_out, dest_write_en_out}, 9'h0A5);
    chk(shift_amount_out, 6'h30);
    chk({div_add_out, booth_digit_out}, 5'h1E);
  endtask
  task automatic t_timing();
    mfd_word_t w;
    logic [3:0] ext [3] = '{4'h0, 4'h9, 4'hF};
    for (int i = 0; i < 3; i++) begin
      w = '0;
      w[67:64] = ext[i];
      step(w, 1'b0, 1'b0, 1'b0);
      chk(n7, 5);
      chk(n8, 7 + 2 * ext[i][3:2]);
      chk(nl, 9 + 2 * ext[i][3:2] + 2 * ext[i][1:0]);
    end
  endtask
  task automatic t_trap_ea();
    mfd_word_t w;
    w = '0;
    w[5:3] = 3'h6;
    step(w, 1'b0, 1'b0, 1'b1);
    chk(trap_take_out, 1'b1);
    chk({ea_update_out, ea_source_reg_low_out, ea_dest_reg_low_out},
      {1'b1, 16'hFFFF, 16'h7FFF});
    w[5:2] = 4'h7;
    step(w, 1'b0, 1'b0, 1'b1);
    chk(trap_take_out, 1'b0);
    chk(ea_dest_reg_low_out, 16'h8001);
  endtask
  task automatic t_parity();
    step(80'h0000_0000_0000_1FC0_0000, 1'b1, 1'b0, 1'b0);
    chk({parity_err_out, dest_write_en_out, next_addr_valid_out},
      {1'b1, 8'h00, 1'b1});
    @(posedge sys_clk_in);
    cs_wr_word_in <= 80'hDEAD_BEEF_0123_4567_89AB;
    tick();
    chk(cs_wr_word_out, u_cs.add_par(80'hDEAD_BEEF_0123_4567_89AB));
  endtask
  task automatic seq(input logic [2:0] op, input logic [16:0] cu,
      input logic cond, input logic [16:0] nxt, input logic emit);
    mfd_word_t w;
    w = '0;
    w[78:70] = cu[16:8];
    w[68] = cu[7];
    w[38:31] = {op, cu[6:2]};
    w[1:0] = cu[1:0];
    step(w, 1'b0, cond, 1'b0);
    if (emit) chk({constant_valid_out, constant_out}, {1'b1, cu});
    else chk({next_addr_valid_out, next_addr_out}, {1'b1, nxt});
  endtask
  task automatic t_seq();
    seq(3'h2, 17'h0_123C, 1'b0, 17'h0_123C, 1'b0);
    seq(3'h6, 17'h0_0500, 1'b0, 17'h0_0500, 1'b0);
    seq(3'h1, 17'h0_AAAA, 1'b0, 17'h0_0501, 1'b0);
    seq(3'h1, 17'h0_AAAA, 1'b1, 17'h0_AAAA, 1'b0);
    seq(3'h0, 17'h0_0000, 1'b0, 17'h0_123D, 1'b0);
    seq(3'h7, 17'h0_0777, 1'b0, 17'h0_0000, 1'b1);
    seq(3'h4, 17'h0_0000, 1'b1, 17'h0_0777, 1'b0);
    seq(3'h5, 17'h0_0040, 1'b1, 17'h0_0040, 1'b0);
    seq(3'h4, 17'h0_0000, 1'b0, 17'h0_0041, 1'b0);
    seq(3'h3, 17'h1_FFFF, 1'b0, 17'h0_0000, 1'b1);
    seq(3'h2, 17'h0_0000, 1'b0, 17'h1_5555, 1'b0);
    seq(3'h2, 17'h0_0004, 1'b0, 17'h0_ABCD, 1'b0);
    seq(3'h2, 17'h0_0308, 1'b0, 17'h0_030D, 1'b0);
  endtask
  initial begin
    cs_wr_word_in = '0;
    branch_cond_in = 1'b0;
    trap_req_in = 1'b0;
    decode_addr_in = 17'h1_5555;
    load_addr_in = 17'h0_ABCD;
    bus_data_high_in = 4'h5;
    ea_source_reg_low_in = 16'h0000;
    ea_dest_reg_low_in = 16'h8000;
    shift_count_in = 6'h3F;
    mult_bits_in = 4'hB;
    div_rem_neg_in = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    tick();
    chk({word_ready_out, a_src_sel_out, next_addr_out},
      {1'b1, 6'h01, 17'h0_0000});
    t_fields();
    t_timing();
    t_trap_ea();
    t_parity();
    t_seq();
    final_report();
  end
endmodule
